// File: bench/adc_core_model.sv
// Purpose: Converter core model that hands raw samples to the filter chain.
// Assumes: Samples count up from 1 while run_in is high, restarting at 1 when idle.
// Notes:   Gap cycles make a slow source; an idle data line toggles every cycle.
`timescale 1ns/1ps
module adc_core_model (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Control from the bench.
  input  wire logic        run_in,
  input  wire logic [3:0]  gap_in,
  // Sample handshake.
  output logic             valid_out,
  output logic [15:0]      data_out,
  input  wire logic        ready_in
);
  logic [15:0] cnt_q;
  logic [3:0]  wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // A sample is held until taken; an idle line never keeps a stale value.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
      data_out  <= 16'h0000;
      cnt_q     <= 16'h0001;
      wait_q    <= 4'h0;
    end else if (valid_out && ready_in) begin
      cnt_q <= cnt_q + 16'h0001;
      if (run_in && gap_in == 4'h0) begin
        data_out <= cnt_q + 16'h0001;
      end else begin
        valid_out <= 1'b0;
        data_out  <= ~cnt_q;
        wait_q    <= gap_in;
      end
    end else if (!valid_out) begin
      data_out <= ~data_out;
      if (!run_in) begin
        cnt_q <= 16'h0001;
      end else if (wait_q == 4'h0) begin
        valid_out <= 1'b1;
        data_out  <= cnt_q;
      end else begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : adc_core_model

// File: bench/adc_output_filter_config_bench.sv
// Purpose: Self-checking bench for the filter configuration block.
// Assumes: APB master tasks; a monitor checks every sample sent to the engine.
// Notes:   Expected samples follow from the source counting up from 1.
`timescale 1ns/1ps
module adc_output_filter_config_bench;
  import filt_pkg::*;
  logic        clk_in = 0, rstn_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic        pready, pslverr, raw_valid, raw_ready, dec2_valid, dft_valid, err;
  logic [15:0] raw_data, dec2_data, dft_data, dec2_first;
  logic        dft_ready = 1, run = 0;
  logic [3:0]  gap = 0;
  logic [2:0]  clock_run;
  logic        rate_fast, first_byp, notch_byp;
  int          num_errors = 0, n_compared = 0, cycles = 0, n_out = 0, n_dec2 = 0;
  int          cur_r = 5, cur_n = 0;
  int          r1tab[4] = '{5, 4, 2, 5};
  int          lens[13] = '{22, 44, 89, 178, 267, 533, 640, 667, 800, 889, 1067, 1333, 1333};

  adc_output_filter_config dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .raw_valid_in(raw_valid), .raw_data_in(raw_data), .raw_ready_out(raw_ready),
    .dec2_valid_out(dec2_valid), .dec2_data_out(dec2_data), .dft_valid_out(dft_valid),
    .dft_data_out(dft_data), .dft_ready_in(dft_ready), .clock_run_out(clock_run),
    .rate_fast_out(rate_fast), .first_bypass_out(first_byp), .notch_bypass_out(notch_byp));
  adc_core_model core_u (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run), .gap_in(gap),
    .valid_out(raw_valid), .data_out(raw_data), .ready_in(raw_ready));

  always #5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison.
  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Expected engine sample: mean of cur_n picks, or one pick without averaging.
  function automatic logic [15:0] exp_out(input int idx);
    int s;
    int nn;
    nn = (cur_n == 0) ? 1 : cur_n;
    s = 0;
    for (int j = idx * nn + 1; j <= (idx + 1) * nn; j++) s += cur_r * j;
    return 16'(s / nn);
  endfunction : exp_out

  ////////////////////////////////////////////////////////////////////////////
  // Monitor of the engine stream and second decimator, plus the hang limit.
  always @(posedge clk_in) begin
    cycles++;
    if (dft_valid === 1'b1 && dft_ready === 1'b1) begin
      chk({16'h0, dft_data}, {16'h0, exp_out(n_out)});
      n_out++;
    end
    if (dec2_valid === 1'b1) begin
      if (n_dec2 == 0) dec2_first = dec2_data;
      n_dec2++;
    end
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB transfer: setup, access until pready, then release.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setcfg(input logic ae, input logic [1:0] an, input logic [1:0] r1,
                        input logic [3:0] r2, input logic [2:0] off);
    logic [31:0] v;
    v = {13'h0, off, an, r1, r2, ae, 6'h00, r1 == 2'd1};
    apb(1'b1, CFG_ADDR, v);
    cur_r = r1tab[r1];
    cur_n = ae ? (2 << an) : 0;
    n_out = 0;
    n_dec2 = 0;
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, v);
  endtask : setcfg

  task automatic stream(input int t);
    run <= 1'b1;
    while (n_out < t) @(posedge clk_in);
    run <= 1'b0;
    gap <= 4'h0;
    repeat (40) @(posedge clk_in);
  endtask : stream

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h0000_0301);
    chk({29'h0, clock_run}, 32'h7);
    chk({29'h0, rate_fast, first_byp, notch_byp}, 32'h4);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'h0000_0020);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, CFG_ADDR, 32'hffff_ffff);
    apb(1'b0, CFG_ADDR, 32'h0);
    chk(rd, 32'h0007_ffd1);
    chk({29'h0, clock_run}, 32'h0);
    chk({29'h0, rate_fast, first_byp, notch_byp}, 32'h7);
    apb(1'b0, 32'h0000_2040, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, CFG_ADDR, (32'h1 << (16 + i)) | 32'h301);
      repeat (2) @(posedge clk_in);
      chk({29'h0, clock_run}, {29'h0, ~(3'b001 << i)});
    end
    for (int c = 0; c < 4; c++) begin
      setcfg(1'b0, 2'd3, 2'(c), 4'd3, 3'b000);
      stream(6);
    end
    for (int a = 0; a < 4; a++) begin
      setcfg(1'b1, 2'(a), 2'd2, 4'd3, 3'b000);
      stream(3);
    end
    setcfg(1'b0, 2'd0, 2'd2, 4'd0, 3'b101);
    run <= 1'b1;
    repeat (300) @(posedge clk_in);
    run <= 1'b0;
    repeat (40) @(posedge clk_in);
    chk(n_out, 0);
    chk(n_dec2, 0);
    for (int c = 0; c < 13; c++) begin
      setcfg(1'b0, 2'd0, 2'd2, 4'(c), 3'b000);
      run <= 1'b1;
      while (n_dec2 == 0) @(posedge clk_in);
      run <= 1'b0;
      chk({16'h0, dec2_first}, 32'(2 * lens[c]));
      repeat (40) @(posedge clk_in);
    end
    setcfg(1'b0, 2'd0, 2'd2, 4'd3, 3'b000);
    dft_ready <= 1'b0;
    run <= 1'b1;
    while (raw_ready !== 1'b0) @(posedge clk_in);
    repeat (5) @(posedge clk_in);
    chk({31'h0, dft_valid}, 32'h1);
    dft_ready <= 1'b1;
    gap <= 4'h3;
    stream(24);
    stop_test();
  end
endmodule : adc_output_filter_config_bench

// File: hdl/adc_output_filter_config.sv
// Purpose: Filter configuration register and decimation, averaging and
//          clock gating of the converter output stream.
// Assumes: Raw samples come from logic on clk_in; APB slave, no wait states.
// Notes:   The decimators pick one sample per ratio; filter arithmetic is
//          outside this block.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// What this block does
// [RQ1] Three clock-off bits at 18, 17, 16 stop transform, wavegen, second decimator.
// [RQ2] Field 15:14 picks averaging over 2, 4, 8 or 16 samples, reset 00.
// [RQ3] While averaging, the averaged stream automatically feeds the transform engine.
// [RQ4] The sample count acts only while the averaging enable bit is set.
// [RQ5] Field 13:12 picks first decimator ratio 5, 4, 2, 5; reset ratio 5.
// [RQ6] Software picks ratio 4 only at 1.6 MSPS; ratios 2 and 5 suit 800 kSPS.
// [RQ7] Field 11:8 resets to 3; codes 0-6 give 22 to 640 samples.
// [RQ8] Codes 7 to 11 give 667, 800, 889, 1067 and 1333 samples.
// [RQ9] Bit 7 enables averaging into the transform engine; clear disables it.
// [RQ10] Bits 31:19 read as zero and ignore writes.
module adc_output_filter_config (
  // Clock and reset.
  input  wire logic                           clk_in,
  input  wire logic                           rstn_in,
  // APB slave.
  input  wire logic                           psel_in,
  input  wire logic                           penable_in,
  input  wire logic                           pwrite_in,
  input  wire logic [31:0]                    paddr_in,
  input  wire logic [31:0]                    pwdata_in,
  output logic      [31:0]                    prdata_out,
  output logic                                pready_out,
  output logic                                pslverr_out,
  // Raw samples from the converter core.
  input  wire logic                           raw_valid_in,
  input  wire logic [filt_pkg::SAMPLE_W-1:0]  raw_data_in,
  output logic                                raw_ready_out,
  // Second decimator output.
  output logic                                dec2_valid_out,
  output logic      [filt_pkg::SAMPLE_W-1:0]  dec2_data_out,
  // Stream to the transform engine.
  output logic                                dft_valid_out,
  output logic      [filt_pkg::SAMPLE_W-1:0]  dft_data_out,
  input  wire logic                           dft_ready_in,
  // Clock runs: 2 transform, 1 wavegen, 0 second decimator.
  output logic      [2:0]                     clock_run_out,
  // Static settings for neighbouring stages.
  output logic                                rate_fast_out,
  output logic                                first_bypass_out,
  output logic                                notch_bypass_out
);
  import filt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders.

  // First decimator ratio from its two-bit code.
  function automatic logic [2:0] first_ratio(input logic [1:0] code);
    case (code)
      2'h0:    first_ratio = DEC1_R0;
      2'h1:    first_ratio = DEC1_R1;
      2'h2:    first_ratio = DEC1_R2;
      default: first_ratio = DEC1_R3;
    endcase
  endfunction : first_ratio

  // Second decimator length; unused codes act as the longest length.
  // [RQ8] codes 7 to 11
  function automatic logic [10:0] second_len(input logic [3:0] code);
    case (code)
      4'h0:    second_len = DEC2_L0;
      4'h1:    second_len = DEC2_L1;
      4'h2:    second_len = DEC2_L2;
      4'h3:    second_len = DEC2_L3;
      4'h4:    second_len = DEC2_L4;
      4'h5:    second_len = DEC2_L5;
      4'h6:    second_len = DEC2_L6;
      4'h7:    second_len = DEC2_L7;
      4'h8:    second_len = DEC2_L8;
      4'h9:    second_len = DEC2_L9;
      4'ha:    second_len = DEC2_L10;
      default: second_len = DEC2_L11;
    endcase
  endfunction : second_len

  // Index of the last sample of an averaging run.
  function automatic logic [3:0] avg_last(input logic [1:0] code);
    case (code)
      2'h0:    avg_last = 4'h1;
      2'h1:    avg_last = 4'h3;
      2'h2:    avg_last = 4'h7;
      default: avg_last = 4'hf;
    endcase
  endfunction : avg_last

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [31:0]          cfg;
    logic [31:0]          rdata;
    logic [2:0]           d1_cnt;
    logic [10:0]          d2_cnt;
    logic [SAMPLE_W-1:0]  s2_dat;
    logic                 s2_vld;
    logic [ACC_W-1:0]     acc;
    logic [3:0]           a_cnt;
    logic [SAMPLE_W-1:0]  dft_dat;
    logic                 dft_vld;
  } state_t;

  state_t               q;
  state_t               d;
  logic                 cfg_wr;
  logic                 take;
  logic                 d1_hit;
  logic                 avg_en;
  logic [1:0]           avg_code;
  logic [ACC_W-1:0]     sum_w;
  logic                 f_in_rdy;
  logic [LEVEL_W-1:0]   f_level;

  // [RQ9] averaging enable bit
  assign avg_en   = q.cfg[AVG_EN_BIT];
  assign avg_code = q.cfg[AVG_NUM_LSB+1:AVG_NUM_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Reads are captured in the setup phase, so the access
  // phase needs no wait state; unknown addresses answer with an error.
  assign cfg_wr      = psel_in & penable_in & pwrite_in & (paddr_in == CFG_ADDR);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in &
                       (paddr_in != CFG_ADDR) & (paddr_in != STAT_ADDR);
  assign prdata_out  = q.rdata;

  // A sample is taken only if the transform slot can move on.
  assign raw_ready_out = (~q.dft_vld | f_in_rdy) & ~cfg_wr;
  assign take          = raw_valid_in & raw_ready_out;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register file, decimators, averager.
  always_comb begin
    d      = q;
    d1_hit = 1'b0;
    sum_w  = q.acc + ACC_W'(raw_data_in);
    d.s2_vld = 1'b0;
    if (psel_in & ~penable_in) begin
      if (paddr_in == CFG_ADDR) begin
        d.rdata = q.cfg;
      end else if (paddr_in == STAT_ADDR) begin
        d.rdata = {21'h000000, f_level, f_in_rdy, q.dft_vld, q.a_cnt};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
    // The slot empties when the FIFO takes it; a new sample below wins.
    if (q.dft_vld & f_in_rdy) begin
      d.dft_vld = 1'b0;
    end
    if (cfg_wr) begin
      // [RQ10] reserved bits dropped
      d.cfg    = pwdata_in & CFG_WMASK;
      d.d1_cnt = 3'h0;
      d.d2_cnt = 11'h000;
      d.acc    = '0;
      d.a_cnt  = 4'h0;
    end else if (take) begin
      // [RQ5] first decimator ratio
      d1_hit = (q.d1_cnt == first_ratio(q.cfg[DEC1_LSB+1:DEC1_LSB]) - 3'h1);
      d.d1_cnt = d1_hit ? 3'h0 : q.d1_cnt + 3'h1;
    end
    // [RQ7] second decimator length
    if (d1_hit & ~q.cfg[DEC2_OFF_BIT]) begin
      if (q.d2_cnt == second_len(q.cfg[DEC2_LSB+3:DEC2_LSB]) - 11'h001) begin
        d.d2_cnt = 11'h000;
        d.s2_dat = raw_data_in;
        d.s2_vld = 1'b1;
      end else begin
        d.d2_cnt = q.d2_cnt + 11'h001;
      end
    end
    // [RQ3] transform source select
    if (d1_hit & ~q.cfg[XFORM_OFF_BIT]) begin
      // [RQ4] enable gates count
      if (!avg_en) begin
        d.dft_dat = raw_data_in;
        d.dft_vld = 1'b1;
      end else if (q.a_cnt == avg_last(avg_code)) begin
        // [RQ2] averaging length by shift
        // The shift count is widened first so that code 3 shifts by four, not zero.
        d.dft_dat = SAMPLE_W'(sum_w >> (3'(avg_code) + 3'h1));
        d.dft_vld = 1'b1;
        d.acc     = '0;
        d.a_cnt   = 4'h0;
      end else begin
        d.acc   = sum_w;
        d.a_cnt = q.a_cnt + 4'h1;
      end
    end
  end

  // State register; reset loads the configuration power-on image.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      q     <= '0;
      q.cfg <= CFG_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // [RQ1] clock runs from off bits
  for (genvar i = 0; i < 3; i++) begin : g_clk
    assign clock_run_out[i] = ~q.cfg[DEC2_OFF_BIT+i];
  end

  assign dec2_valid_out   = q.s2_vld;
  assign dec2_data_out    = q.s2_dat;
  assign rate_fast_out    = q.cfg[RATE_BIT];
  assign first_bypass_out = q.cfg[BYP1_BIT];
  assign notch_bypass_out = q.cfg[NOTCH_BYP_BIT];

  // Seventeen-word buffer in front of the transform engine: sixteen in memory plus the read register slot.
  sample_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_DEPTH),
    .LW    (LEVEL_W)
  ) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (q.dft_vld),
    .in_data_in    (q.dft_dat),
    .in_ready_out  (f_in_rdy),
    .out_valid_out (dft_valid_out),
    .out_data_out  (dft_data_out),
    .out_ready_in  (dft_ready_in),
    .level_out     (f_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Reserved bits never read back as ones.
  reserved_read_a: assert property ( // [RQ10]
    psel_in & penable_in & ~pwrite_in & (paddr_in == CFG_ADDR) |-> prdata_out[31:19] == '0)
    else $error("reserved config bits read nonzero");

  // Writes to reserved bits leave them clear.
  reserved_write_a: assert property ( // [RQ10]
    cfg_wr |=> q.cfg[31:19] == '0)
    else $error("reserved config bits stored");

  // A clock-off bit written as one stops that clock next cycle.
  clock_gate_a: assert property ( // [RQ1]
    cfg_wr |=> clock_run_out == ~$past(pwdata_in[18:16]))
    else $error("clock run does not follow off bits");

  // Sample count field stores what was written.
  avg_field_a: assert property ( // [RQ2]
    cfg_wr |=> avg_code == $past(pwdata_in[15:14]))
    else $error("average count field not stored");

  // Without averaging each decimated sample goes straight to the engine.
  direct_feed_a: assert property ( // [RQ3]
    d1_hit & ~avg_en & ~q.cfg[XFORM_OFF_BIT] |=> q.dft_vld && q.a_cnt == 4'h0)
    else $error("decimated sample not forwarded");

  // An averaging run ends exactly at its chosen length.
  avg_run_end_a: assert property ( // [RQ4]
    d1_hit & avg_en & ~q.cfg[XFORM_OFF_BIT] & (q.a_cnt == avg_last(avg_code))
    |=> q.dft_vld && q.a_cnt == 4'h0 && q.acc == '0)
    else $error("averaging run did not close");

  // With averaging off the run counter stays idle.
  avg_off_idle_a: assert property ( // [RQ9]
    ~avg_en |-> q.a_cnt == 4'h0)
    else $error("averaging counter moved while disabled");

  // First decimator counter stays below its ratio.
  dec1_bound_a: assert property ( // [RQ5]
    q.d1_cnt < first_ratio(q.cfg[DEC1_LSB+1:DEC1_LSB]))
    else $error("first decimator count out of range");

  // A second decimator output follows the last sample of its run.
  dec2_pulse_a: assert property ( // [RQ8]
    q.s2_vld |-> $past(q.d2_cnt) == second_len(q.cfg[DEC2_LSB+3:DEC2_LSB]) - 11'h001)
    else $error("second decimator fired at wrong count");

  // Second decimator counter stays below its length.
  dec2_bound_a: assert property ( // [RQ7]
    q.d2_cnt < second_len(q.cfg[DEC2_LSB+3:DEC2_LSB]))
    else $error("second decimator count out of range");

  avg_out_c:  cover property (q.dft_vld & avg_en & (avg_code == 2'h3));
  dec2_out_c: cover property (q.s2_vld);
  fifo_full_c: cover property (~f_in_rdy & q.dft_vld);

endmodule : adc_output_filter_config

// File: hdl/sample_fifo.sv
// Purpose: Sample FIFO between the averaging stage and the transform engine.
// Assumes: Single clock; the drain side may stall at will.
// Notes:   Read data come out of a register that forms one extra slot.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  // Clock and reset.
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  // Filling side.
  input  wire logic          in_valid_in,
  input  wire logic [W-1:0]  in_data_in,
  output logic               in_ready_out,
  // Draining side.
  output logic               out_valid_out,
  output logic [W-1:0]       out_data_out,
  input  wire logic          out_ready_in,
  // Fill level of the memory.
  output logic [LW-1:0]      level_out
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
    logic [W-1:0]  rdat;
    logic          rvld;
  } fifo_t;

  fifo_t      q;
  fifo_t      d;
  logic [W-1:0] mem [DEPTH];
  logic       push;
  logic       pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and output slot update; a pop refills the slot from memory.
  always_comb begin
    d    = q;
    push = in_valid_in & in_ready_out;
    pop  = (q.cnt != '0) & (~q.rvld | out_ready_in);
    if (out_ready_in) begin
      d.rvld = 1'b0;
    end
    if (pop) begin
      d.rdat = mem[q.rp];
      d.rvld = 1'b1;
      d.rp   = q.rp + 1'b1;
    end
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    d.cnt = q.cnt + LW'(push) - LW'(pop);
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage array, written on a push.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[q.wp] <= in_data_in;
    end
  end

  // Ready stays honest: low only while the memory is full.
  assign in_ready_out  = (q.cnt != LW'(DEPTH));
  assign out_valid_out = q.rvld;
  assign out_data_out  = q.rdat;
  assign level_out     = q.cnt;

endmodule : sample_fifo

// File: include/filt_pkg.sv
// Purpose: Constants shared by the output filter chain and its sample FIFO.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Every offset, configuration field position, reset value and ratio lives here.
package filt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [31:0] CFG_ADDR   = 32'h0000_2044;
  localparam logic [31:0] STAT_ADDR  = 32'h0000_2048;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0301;
  localparam logic [31:0] CFG_WMASK  = 32'h0007_ffd1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of adc_filter_config.
  localparam int XFORM_OFF_BIT = 18;
  localparam int WAVE_OFF_BIT  = 17;
  localparam int DEC2_OFF_BIT  = 16;
  localparam int AVG_NUM_LSB   = 14;
  localparam int DEC1_LSB      = 12;
  localparam int DEC2_LSB      = 8;
  localparam int AVG_EN_BIT    = 7;
  localparam int BYP1_BIT      = 6;
  localparam int NOTCH_BYP_BIT = 4;
  localparam int RATE_BIT      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Data widths and depths.
  localparam int SAMPLE_W   = 16;
  localparam int ACC_W      = 20;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // First decimator ratios, codes 0 to 3.
  localparam logic [2:0] DEC1_R0 = 3'h5;
  localparam logic [2:0] DEC1_R1 = 3'h4;
  localparam logic [2:0] DEC1_R2 = 3'h2;
  localparam logic [2:0] DEC1_R3 = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Second decimator lengths, codes 0 to 11.
  localparam logic [10:0] DEC2_L0  = 11'h016;
  localparam logic [10:0] DEC2_L1  = 11'h02c;
  localparam logic [10:0] DEC2_L2  = 11'h059;
  localparam logic [10:0] DEC2_L3  = 11'h0b2;
  localparam logic [10:0] DEC2_L4  = 11'h10b;
  localparam logic [10:0] DEC2_L5  = 11'h215;
  localparam logic [10:0] DEC2_L6  = 11'h280;
  localparam logic [10:0] DEC2_L7  = 11'h29b;
  localparam logic [10:0] DEC2_L8  = 11'h320;
  localparam logic [10:0] DEC2_L9  = 11'h379;
  localparam logic [10:0] DEC2_L10 = 11'h42b;
  localparam logic [10:0] DEC2_L11 = 11'h535;

endpackage : filt_pkg
